// ==== include/pwr_arb_pkg.sv ====
`default_nettype none
package pwr_arb_pkg;
  // power modes
  localparam logic [1:0] PMODE_FIELD   = 2'h0;
  localparam logic [1:0] PMODE_HARVEST = 2'h1;
  localparam logic [1:0] PMODE_EXT_LO  = 2'h2;
  localparam logic [1:0] PMODE_EXT_HI  = 2'h3;
  // arbitration modes
  localparam logic       ARB_FCFS      = 1'h0;
  localparam logic       ARB_RF_FIRST  = 1'h1;
  // harvester resistance codes
  localparam logic [1:0] RREG_OFF      = 2'h0;
  localparam logic [1:0] RREG_100      = 2'h1;
  localparam logic [1:0] RREG_50       = 2'h2;
  localparam logic [1:0] RREG_25       = 2'h3;
  // harvester voltage: base and step in millivolts, top code
  localparam int         VREG_BASE_MV  = 1800;
  localparam int         VREG_STEP_MV  = 100;
  localparam logic [4:0] VREG_MAX_CODE = 5'h1b;
  // field positions in config byte zero
  localparam int         CFG0_ARB_BIT    = 0;
  localparam int         CFG0_SILENT_BIT = 1;
  localparam int         CFG0_PMODE_LSB  = 2;
  // field positions in config byte one
  localparam int         CFG1_VREG_LSB = 0;
  localparam int         CFG1_RREG_LSB = 5;
  // battery switch hold time
  localparam int         CLK_SYS_MHZ     = 100;
  localparam int         BAT_HOLD_US_X10 = 7;   // 0.7 ms = 7 tenths of a ms
  localparam int         BAT_HOLD_CYC    = BAT_HOLD_US_X10 * 100 * CLK_SYS_MHZ;
  // reset values
  localparam logic [7:0] CFG0_RESET = 8'h00;
  localparam logic [7:0] CFG1_RESET = 8'h00;

  // supply selection
  typedef struct packed {
    logic logic_on;
    logic from_field;
    logic from_battery;
    logic battery_switch;
  } supply_s;

  // harvester decoded settings
  typedef struct packed {
    logic        enable;
    logic [1:0]  rreg;
    logic [4:0]  vreg;
    logic [12:0] millivolts;
  } harvest_s;
endpackage
`default_nettype wire

// ==== logic/sync2.sv ====
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // two-stage synchroniser
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== logic/rf_event_link.sv ====
`timescale 1ns/100ps
`default_nettype none
// carries rf-domain pulses into the system domain by toggles
module rf_event_link #(
  parameter int N = 3
) (
  // rf side
  input  wire logic         clk_rf_i,
  input  wire logic         reset_n_i,
  input  wire logic [N-1:0] pulse_rf_i,
  // system side
  input  wire logic         clk_sys_i,
  output logic      [N-1:0] pulse_sys_o
);
  logic [N-1:0] tog_rf;
  logic [N-1:0] tog_sys;
  logic [N-1:0] tog_last;

  // toggle per event on rf clock
  always_ff @(posedge clk_rf_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_rf <= '0;
    end else begin
      tog_rf <= tog_rf ^ pulse_rf_i;
    end
  end

  sync2 #(.WIDTH(N)) u_sync (
    .clk_i     (clk_sys_i),
    .reset_n_i (reset_n_i),
    .d_i       (tog_rf),
    .q_o       (tog_sys)
  );

  // edge of synchronised toggle gives one pulse
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_last    <= '0;
      pulse_sys_o <= '0;
    end else begin
      tog_last    <= tog_sys;
      pulse_sys_o <= tog_sys ^ tog_last;
    end
  end
endmodule
`default_nettype wire

// ==== logic/power_manager_eeprom_arbiter.sv ====
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RQ1] mode 0: no field, select high: supply off
// [RQ2] mode 0: field above threshold uses field supply
// [RQ3] battery switch closes: no field, select low
// [RQ4] switch held 0.7 ms after select rises
// [RQ5] switch held during host eeprom write
// [RQ6] host waits 300 us before first clock
// [RQ7] battery powered: only memory/register access
// [RQ8] field lost, select low: move to battery
// [RQ9] mode 1: harvester on only with tunneling/extended
// [RQ10] mode 1 without tunneling: resistance forced zero
// [RQ11] host completes init for modes 2, 3
// [RQ12] modes 2, 3: external supply, never off; logic_on follows battery_ok, so logic goes off without the battery pin
// [RQ13] arbitration 0: first come first served
// [RQ14] arbitration 0: rf write during host write nak
// [RQ15] arbitration 0: host write during rf write errors
// [RQ16] arbitration 1: field on aborts host write
// [RQ17] arbitration 1: rf read/write aborts host write
// [RQ18] host repeats an aborted write
// [RQ19] harvester only in power modes 0, 1
// [RQ20] resistance decode: off, 100, 50, 25 ohm
// [RQ21] voltage decode: 1.8 V plus 100 mV steps
// [RQ22] silent and low supply: rf disabled
module power_manager_eeprom_arbiter #(
  parameter int BAT_HOLD_CYCLES = pwr_arb_pkg::BAT_HOLD_CYC
) (
  // system clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_n_i,
  // rf link clock and rf-side events
  input  wire logic                  clk_rf_i,
  input  wire logic                  rf_write_req_i,   // rf write command pulse
  input  wire logic                  rf_rw_cmd_i,      // rf read or write command pulse
  input  wire logic                  rf_write_done_i,  // rf write finished pulse
  // analog status pins and slave select (asynchronous)
  input  wire logic                  field_power_on_threshold_i, // field supply above threshold
  input  wire logic                  external_battery_supply_i,  // battery present
  input  wire logic                  ext_supply_low_i,           // below silent threshold
  input  wire logic                  slave_select_n_i,
  // host write requests (system domain)
  input  wire logic                  host_write_req_i,
  input  wire logic                  host_write_done_i,
  // configuration
  input  wire logic [7:0]            chip_config_byte_zero_i,
  input  wire logic [7:0]            chip_config_byte_one_i,
  input  wire logic                  tunnel_or_ext_en_i,
  // supply control
  output pwr_arb_pkg::supply_s       supply_o,
  output logic                       harvest_drive_o,
  output logic                       harvest_oe_o,
  output pwr_arb_pkg::harvest_s      harvest_o,
  // arbitration results, host limit and rf disable flags
  output logic                       host_write_busy_o,
  output logic                       rf_write_busy_o,
  output logic                       rf_nak_o,
  output logic                       host_write_abort_o,
  output logic                       access_error_irq_o,
  output logic                       host_ops_limited_o,
  output logic                       rf_disable_o
);
  localparam int HW = $clog2(BAT_HOLD_CYCLES + 1);

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_HOST,
    ARB_RF
  } arb_state_e;

  logic [3:0]   pins_sync;
  logic         field_on;
  logic         battery_ok;
  logic         ext_low;
  logic         ss_low;
  logic         field_last;
  logic         field_rise;
  logic [2:0]   rf_ev;
  logic         rf_wr;
  logic         rf_rw;
  logic         rf_done;
  logic [HW-1:0] hold_cnt;
  logic         bat_closed;
  logic         next_bat_closed;
  logic [1:0]   pmode;
  logic         arb_mode;
  logic         silent_en;
  logic [1:0]   rreg_cfg;
  logic [4:0]   vreg_cfg;
  logic         harvest_en;
  logic [1:0]   next_rreg;
  arb_state_e   arb_state;

  // pins into the system domain
  sync2 #(.WIDTH(4)) u_pin_sync (
    .clk_i     (clk_sys_i),
    .reset_n_i (reset_n_i),
    .d_i       ({field_power_on_threshold_i, external_battery_supply_i,
                 ext_supply_low_i, slave_select_n_i}),
    .q_o       (pins_sync)
  );
  assign field_on   = pins_sync[3];
  assign battery_ok = pins_sync[2];
  assign ext_low    = pins_sync[1];
  assign ss_low     = ~pins_sync[0];

  // rf command events cross from the link clock
  rf_event_link #(.N(3)) u_rf_link (
    .clk_rf_i    (clk_rf_i),
    .reset_n_i   (reset_n_i),
    .pulse_rf_i  ({rf_write_req_i, rf_rw_cmd_i, rf_write_done_i}),
    .clk_sys_i   (clk_sys_i),
    .pulse_sys_o (rf_ev)
  );
  assign rf_wr   = rf_ev[2];
  assign rf_rw   = rf_ev[1];
  assign rf_done = rf_ev[0];

  // configuration fields
  assign pmode     = chip_config_byte_zero_i[pwr_arb_pkg::CFG0_PMODE_LSB +: 2];
  assign arb_mode  = chip_config_byte_zero_i[pwr_arb_pkg::CFG0_ARB_BIT];
  assign silent_en = chip_config_byte_zero_i[pwr_arb_pkg::CFG0_SILENT_BIT];
  assign rreg_cfg  = chip_config_byte_one_i[pwr_arb_pkg::CFG1_RREG_LSB +: 2];
  assign vreg_cfg  = chip_config_byte_one_i[pwr_arb_pkg::CFG1_VREG_LSB +: 5];

  // field rising edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      field_last <= 1'b0;
    end else begin
      field_last <= field_on;
    end
  end
  assign field_rise = field_on & ~field_last;

  // battery switch request and release hold
  always_comb begin
    next_bat_closed = 1'b0;
    // [RQ3] select low without field
    if (ss_low && !field_on) begin
      next_bat_closed = 1'b1;
    end
    // [RQ4] hold after select rises
    if (bat_closed && hold_cnt != '0 && !field_on) begin
      next_bat_closed = 1'b1;
    end
    // [RQ5] host write keeps switch
    if (arb_state == ARB_HOST && !field_on) begin
      next_bat_closed = 1'b1;
    end
    // [RQ8] field lost with select low
    if (ss_low && !field_on && !battery_ok) begin
      next_bat_closed = 1'b0;
    end
  end

  // hold counter reloads while select is low
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_cnt   <= '0;
      bat_closed <= 1'b0;
    end else begin
      bat_closed <= next_bat_closed;
      if (ss_low || arb_state == ARB_HOST) begin
        hold_cnt <= HW'(BAT_HOLD_CYCLES);
      end else if (hold_cnt != '0) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
    end
  end

  // supply source selection per power mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supply_o <= '0;
    end else begin
      supply_o.battery_switch <= next_bat_closed;
      case (pmode)
        pwr_arb_pkg::PMODE_FIELD: begin
          // [RQ2] field supply above threshold
          supply_o.from_field   <= field_on;
          supply_o.from_battery <= next_bat_closed;
          // [RQ1] off without field or select
          supply_o.logic_on     <= field_on | next_bat_closed;
        end
        pwr_arb_pkg::PMODE_HARVEST: begin
          supply_o.from_field   <= field_on;
          supply_o.from_battery <= 1'b0;
          supply_o.logic_on     <= field_on;
        end
        pwr_arb_pkg::PMODE_EXT_LO, pwr_arb_pkg::PMODE_EXT_HI: begin
          // [RQ12] external supply keeps logic up only while battery_ok is high
          supply_o.from_field   <= 1'b0;
          supply_o.from_battery <= battery_ok;
          supply_o.logic_on     <= battery_ok;
        end
        default: begin
          supply_o <= '0;
        end
      endcase
    end
  end

  // harvester enable and resistance
  always_comb begin
    harvest_en = 1'b0;
    next_rreg  = rreg_cfg;
    case (pmode)
      // [RQ19] only modes 0 and 1
      pwr_arb_pkg::PMODE_FIELD: begin
        harvest_en = 1'b1;
      end
      pwr_arb_pkg::PMODE_HARVEST: begin
        // [RQ9] tunneling decides drive
        harvest_en = tunnel_or_ext_en_i;
        // [RQ10] resistance forced zero
        if (!tunnel_or_ext_en_i) begin
          next_rreg = pwr_arb_pkg::RREG_OFF;
        end
      end
      default: begin
        harvest_en = 1'b0;
      end
    endcase
  end

  // decoded harvester outputs
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      harvest_o       <= '0;
      harvest_drive_o <= 1'b0;
      harvest_oe_o    <= 1'b0;
    end else begin
      harvest_o.rreg   <= next_rreg;
      // [RQ20] code zero disables the output
      harvest_o.enable <= harvest_en && next_rreg != pwr_arb_pkg::RREG_OFF;
      // [RQ21] voltage clamps at top code
      harvest_o.vreg   <= (vreg_cfg > pwr_arb_pkg::VREG_MAX_CODE) ?
                          pwr_arb_pkg::VREG_MAX_CODE : vreg_cfg;
      harvest_o.millivolts <= 13'(pwr_arb_pkg::VREG_BASE_MV) +
                              13'((vreg_cfg > pwr_arb_pkg::VREG_MAX_CODE) ?
                              pwr_arb_pkg::VREG_MAX_CODE : vreg_cfg) *
                              13'(pwr_arb_pkg::VREG_STEP_MV);
      // [RQ20] code zero tristates pin
      harvest_drive_o  <= harvest_en && next_rreg != pwr_arb_pkg::RREG_OFF;
      harvest_oe_o     <= harvest_en && next_rreg != pwr_arb_pkg::RREG_OFF;
    end
  end

  // eeprom write arbiter
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arb_state          <= ARB_IDLE;
      rf_nak_o           <= 1'b0;
      host_write_abort_o <= 1'b0;
      access_error_irq_o <= 1'b0;
    end else begin
      rf_nak_o           <= 1'b0;
      host_write_abort_o <= 1'b0;
      access_error_irq_o <= 1'b0;
      case (arb_state)
        ARB_IDLE: begin
          // [RQ13] first come first served
          if (rf_wr) begin
            arb_state <= ARB_RF;
          end else if (host_write_req_i) begin
            arb_state <= ARB_HOST;
          end
        end
        ARB_HOST: begin
          if (arb_mode == pwr_arb_pkg::ARB_RF_FIRST && (field_rise || rf_rw)) begin
            // [RQ16] field on aborts host
            // [RQ17] rf command aborts host
            host_write_abort_o <= 1'b1;
            access_error_irq_o <= 1'b1;
            arb_state          <= rf_wr ? ARB_RF : ARB_IDLE;
          end else if (host_write_done_i) begin
            arb_state <= ARB_IDLE;
          end else if (rf_wr) begin
            // [RQ14] rf write refused
            rf_nak_o <= 1'b1;
          end
        end
        ARB_RF: begin
          // [RQ15] host write during rf
          if (host_write_req_i) begin
            access_error_irq_o <= 1'b1;
          end
          if (rf_done) begin
            arb_state <= ARB_IDLE;
          end
        end
        default: begin
          arb_state <= ARB_IDLE;
        end
      endcase
    end
  end

  // status flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_write_busy_o  <= 1'b0;
      rf_write_busy_o    <= 1'b0;
      host_ops_limited_o <= 1'b0;
      rf_disable_o       <= 1'b0;
    end else begin
      host_write_busy_o  <= arb_state == ARB_HOST;
      rf_write_busy_o    <= arb_state == ARB_RF;
      // [RQ7] battery powered limits host ops
      host_ops_limited_o <= next_bat_closed && pmode == pwr_arb_pkg::PMODE_FIELD;
      // [RQ22] silent mode mutes rf
      rf_disable_o       <= silent_en & ext_low;
    end
  end
endmodule
`default_nettype wire

// ==== tb/pwr_arb_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwr_arb_chk #(
  parameter int BAT_HOLD_CYCLES = 50
) (
  // clock, reset and pins
  input wire logic                  clk_sys_i,
  input wire logic                  reset_n_i,
  input wire logic                  field_power_on_threshold_i,
  input wire logic                  external_battery_supply_i,
  input wire logic                  ext_supply_low_i,
  input wire logic                  slave_select_n_i,
  input wire logic                  host_write_req_i,
  input wire logic [7:0]            chip_config_byte_zero_i,
  input wire logic [7:0]            chip_config_byte_one_i,
  input wire logic                  tunnel_or_ext_en_i,
  // watched outputs
  input wire pwr_arb_pkg::supply_s  supply_o,
  input wire pwr_arb_pkg::harvest_s harvest_o,
  input wire logic                  harvest_oe_o,
  input wire logic                  host_write_busy_o,
  input wire logic                  rf_write_busy_o,
  input wire logic                  rf_nak_o,
  input wire logic                  host_write_abort_o,
  input wire logic                  access_error_irq_o,
  input wire logic                  rf_disable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [1:0] pmode = chip_config_byte_zero_i[3:2];
  wire logic       arb   = chip_config_byte_zero_i[0];
  int unsigned     ss_hi;
  // cycles since select went high
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ss_hi <= 0;
    end else begin
      ss_hi <= slave_select_n_i ? ss_hi + 1 : 0;
    end
  end
  // steps of a bare mode 1 setting and of the error pulse
  sequence pm1_bare;
    (pmode == pwr_arb_pkg::PMODE_HARVEST && !tunnel_or_ext_en_i)[*5];
  endsequence
  sequence irq_soon;
    ##[0:1] access_error_irq_o;
  endsequence
  field_supply_a: assert property (
    (field_power_on_threshold_i && pmode == pwr_arb_pkg::PMODE_FIELD)[*5]
    |-> supply_o.logic_on && supply_o.from_field) else $error("field supply not used");
  ext_keeps_on_a: assert property (
    (pmode[1] && external_battery_supply_i)[*5] |-> supply_o.logic_on)
    else $error("supply off in external mode");
  bat_hold_a: assert property (
    $fell(supply_o.battery_switch) && !field_power_on_threshold_i && pmode == 2'h0
    |-> ss_hi >= BAT_HOLD_CYCLES) else $error("battery switch opened early");
  harvest_off_a: assert property (
    (pmode[1])[*5] |-> !harvest_oe_o && !harvest_o.enable) else $error("harvester on");
  rreg_forced_a: assert property (
    pm1_bare |-> harvest_o.rreg == pwr_arb_pkg::RREG_OFF && !harvest_oe_o)
    else $error("resistance not forced off");
  vreg_decode_a: assert property (
    ($stable(chip_config_byte_one_i) && chip_config_byte_one_i[4:0] <= 5'h1b)[*5]
    ##0 harvest_o.enable |-> harvest_o.millivolts == 13'(pwr_arb_pkg::VREG_BASE_MV
    + pwr_arb_pkg::VREG_STEP_MV * int'(chip_config_byte_one_i[4:0])))
    else $error("voltage decode wrong");
  silent_rf_a: assert property (
    (chip_config_byte_zero_i[1] && ext_supply_low_i)[*5] |-> rf_disable_o)
    else $error("rf not silenced");
  host_grant_a: assert property (
    host_write_req_i && !host_write_busy_o && !rf_write_busy_o |-> ##[1:2] host_write_busy_o)
    else $error("host write not granted");
  nak_cause_a: assert property (
    rf_nak_o |-> arb == pwr_arb_pkg::ARB_FCFS && $past(host_write_busy_o))
    else $error("nak without host write");
  host_irq_a: assert property (
    host_write_req_i && rf_write_busy_o && arb == pwr_arb_pkg::ARB_FCFS
    |-> ##[1:2] access_error_irq_o) else $error("no access error");
  abort_cause_a: assert property (
    host_write_abort_o |-> (arb == pwr_arb_pkg::ARB_RF_FIRST && $past(host_write_busy_o))
    ##0 irq_soon) else $error("abort wrong");
endmodule
bind power_manager_eeprom_arbiter pwr_arb_chk #(.BAT_HOLD_CYCLES(BAT_HOLD_CYCLES))
  chk_u (.*);
`default_nettype wire

// ==== tb/host_mcu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model #(
  parameter int SETUP_CYC = 30
) (
  // clock
  input  wire logic clk_sys_i,
  // host lines
  output logic      slave_select_n_o,
  output logic      write_req_o,
  output logic      write_done_o
);
  // idle: deselected, no strobes
  initial begin
    slave_select_n_o = 1'h1;
    write_req_o      = 1'h0;
    write_done_o     = 1'h0;
  end
  task automatic select_low();
    @(negedge clk_sys_i);
    slave_select_n_o = 1'h0;
    repeat (SETUP_CYC) @(negedge clk_sys_i);
  endtask
  task automatic select_high();
    @(negedge clk_sys_i);
    slave_select_n_o = 1'h1;
  endtask
  task automatic pulse(input bit done);
    @(negedge clk_sys_i);
    write_done_o = done;
    write_req_o  = !done;
    @(negedge clk_sys_i);
    write_done_o = 1'h0;
    write_req_o  = 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb;
  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic       tun, low, en;
    logic [1:0] rreg;
    logic       dis;
  } row_s;
  logic                  clk_sys_i = 1'h0;
  logic                  clk_rf = 1'h0;
  logic                  reset_n = 1'h0;
  logic                  field = 1'h1;
  logic                  bat = 1'h1;
  logic                  low = 1'h0;
  logic                  tun = 1'h0;
  logic                  clr = 1'h0;
  logic [7:0]            cfg0 = 8'h00;
  logic [7:0]            cfg1 = 8'h00;
  logic [2:0]            rf_ev = 3'h0;
  logic [2:0]            seen = 3'h0;
  logic                  ss_n, wr_req, wr_done, drive, oe, h_busy, r_busy;
  logic                  nak, abrt, irq, lim, rf_dis;
  pwr_arb_pkg::supply_s  supply;
  pwr_arb_pkg::harvest_s harv;
  int                    error_cnt = 0;
  int                    checked = 0;
  row_s                  rows[8];
  // clocks, link clock offset in phase
  always #5 clk_sys_i = ~clk_sys_i;
  initial begin
    #3.3;
    forever #32 clk_rf = ~clk_rf;
  end
  power_manager_eeprom_arbiter #(.BAT_HOLD_CYCLES(50)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n), .clk_rf_i(clk_rf),
    .rf_write_req_i(rf_ev[0]), .rf_rw_cmd_i(rf_ev[1]), .rf_write_done_i(rf_ev[2]),
    .field_power_on_threshold_i(field), .external_battery_supply_i(bat),
    .ext_supply_low_i(low), .slave_select_n_i(ss_n), .host_write_req_i(wr_req),
    .host_write_done_i(wr_done), .chip_config_byte_zero_i(cfg0),
    .chip_config_byte_one_i(cfg1), .tunnel_or_ext_en_i(tun), .supply_o(supply),
    .harvest_drive_o(drive), .harvest_oe_o(oe), .harvest_o(harv),
    .host_write_busy_o(h_busy), .rf_write_busy_o(r_busy), .rf_nak_o(nak),
    .host_write_abort_o(abrt), .access_error_irq_o(irq), .host_ops_limited_o(lim),
    .rf_disable_o(rf_dis));
  host_mcu_model #(.SETUP_CYC(30)) host_u (.clk_sys_i(clk_sys_i),
    .slave_select_n_o(ss_n), .write_req_o(wr_req), .write_done_o(wr_done));
  // sticky record of result pulses
  always @(posedge clk_sys_i) begin
    seen <= clr ? 3'h0 : seen | {irq, abrt, nak};
  end
  task automatic rf_pulse(input int k);
    @(negedge clk_rf);
    rf_ev[k] = 1'h1;
    @(negedge clk_rf);
    rf_ev = 3'h0;
    repeat (2) @(negedge clk_rf);
  endtask
  task automatic wait_clr(input int n);
    repeat (n) @(negedge clk_sys_i);
    clr = 1'h1;
    @(negedge clk_sys_i);
    clr = 1'h0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  // main sequence
  initial begin
    rows[0] = {8'h00, 8'h00, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0};
    rows[1] = {8'h02, 8'h20, 1'h0, 1'h0, 1'h1, 2'h1, 1'h0};
    rows[2] = {8'h00, 8'h5b, 1'h0, 1'h0, 1'h1, 2'h2, 1'h0};
    rows[3] = {8'h00, 8'h61, 1'h0, 1'h1, 1'h1, 2'h3, 1'h0};
    rows[4] = {8'h04, 8'h61, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0};
    rows[5] = {8'h04, 8'h61, 1'h1, 1'h0, 1'h1, 2'h3, 1'h0};
    rows[6] = {8'h08, 8'h61, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0};
    rows[7] = {8'h0e, 8'h61, 1'h0, 1'h1, 1'h0, 2'h0, 1'h1};
    repeat (6) @(negedge clk_sys_i);
    reset_n = 1'h1;
    foreach (rows[i]) begin
      @(negedge clk_sys_i);
      {cfg0, cfg1, tun, low} = {rows[i].cfg0, rows[i].cfg1, rows[i].tun, rows[i].low};
      repeat (6) @(negedge clk_sys_i);
      `CHK(harv.enable, rows[i].en)
      `CHK(oe, rows[i].en)
      `CHK(drive, rows[i].en)
      if (!cfg0[3]) `CHK(harv.rreg, rows[i].rreg)
      if (rows[i].en) `CHK(harv.millivolts, 13'(1800 + 100 * cfg1[4:0]))
      `CHK(rf_dis, rows[i].dis)
      $display("row %0d done", i);
    end
    {cfg0, cfg1, tun, low, field} = '0;
    repeat (60) @(negedge clk_sys_i);
    host_u.select_low();
    `CHK(supply, 4'hb)
    `CHK(lim, 1'h1)
    host_u.select_high();
    repeat (40) @(negedge clk_sys_i);
    `CHK(supply.battery_switch, 1'h1)
    repeat (20) @(negedge clk_sys_i);
    `CHK(supply, 4'h0)
    host_u.select_low();
    host_u.pulse(1'b0);
    host_u.select_high();
    repeat (70) @(negedge clk_sys_i);
    `CHK(supply.battery_switch, 1'h1)
    host_u.pulse(1'b1);
    repeat (60) @(negedge clk_sys_i);
    `CHK(supply, 4'h0)
    cfg0 = 8'h08;
    repeat (6) @(negedge clk_sys_i);
    `CHK(supply, 4'ha)
    bat = 1'h0;
    repeat (6) @(negedge clk_sys_i);
    `CHK(supply, 4'h0)
    bat = 1'h1;
    cfg0 = 8'h00;
    repeat (6) @(negedge clk_sys_i);
    field = 1'h1;
    repeat (6) @(negedge clk_sys_i);
    `CHK(supply, 4'hc)
    host_u.select_low();
    field = 1'h0;
    repeat (6) @(negedge clk_sys_i);
    `CHK(supply, 4'hb)
    host_u.select_high();
    field = 1'h1;
    $display("supply test done");
    host_u.pulse(1'b0);
    wait_clr(3);
    `CHK(h_busy, 1'h1)
    rf_pulse(0);
    repeat (4) @(negedge clk_sys_i);
    `CHK(seen[0], 1'h1)
    host_u.pulse(1'b1);
    rf_pulse(0);
    `CHK(r_busy, 1'h1)
    wait_clr(0);
    host_u.pulse(1'b0);
    repeat (4) @(negedge clk_sys_i);
    `CHK(seen[2], 1'h1)
    `CHK(h_busy, 1'h0)
    rf_pulse(2);
    $display("arbitration 0 test done");
    cfg0 = 8'h01;
    field = 1'h0;
    host_u.pulse(1'b0);
    wait_clr(8);
    field = 1'h1;
    repeat (8) @(negedge clk_sys_i);
    `CHK(seen[2:1], 2'h3)
    `CHK(h_busy, 1'h0)
    host_u.pulse(1'b0);
    wait_clr(4);
    rf_pulse(1);
    repeat (6) @(negedge clk_sys_i);
    `CHK(seen[2:1], 2'h3)
    $display("arbitration 1 test done");
    reset_n = 1'h0;
    repeat (3) @(negedge clk_sys_i);
    `CHK(supply, 4'h0)
    `CHK(h_busy, 1'h0)
    reset_n = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    $display("reset test done");
    close_out();
  end
endmodule
`default_nettype wire
